// ===== pkg/inhibit_pin_pkg.sv
// Purpose: Shared constants and types for the rear inhibit pin block
// Assumes: 10 MHz system clock
// Notes:   State travels as one packed struct
package inhibit_pin_pkg;

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned PWM_WIDTH      = 16;
  localparam logic        OUT_ON_RESET   = 1'b0;
  localparam logic        PROT_ON_RESET  = 1'b0;
  localparam logic [1:0]  SYNC_RESET     = 2'b11;
  localparam logic [PWM_WIDTH-1:0] PWM_CNT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PIN_IN_LIVING,
    PIN_IN_LATCH,
    PIN_OUT_LEVEL,
    PIN_OUT_PWM
  } pin_mode_e;

  typedef struct packed {
    pin_mode_e             mode;
    logic                  invert;
    logic                  out_level_true;
    logic [PWM_WIDTH-1:0]  pwm_period;
    logic [PWM_WIDTH-1:0]  pwm_high;
  } pin_cfg_s;

  typedef struct packed {
    logic                  output_on;
    logic                  protection;
    logic [1:0]            sync;
    logic                  pin_prev;
    logic [PWM_WIDTH-1:0]  pwm_cnt;
    logic                  drive_level;
    logic                  drive_en;
  } pin_state_s;

endpackage

// ===== rtl/external_output_inhibit_pin.sv
// Purpose: Control logic behind the configurable inhibit pin
// Assumes: Pin level arrives asynchronously; pull-up makes an open pin read high
// Notes:   Pin is three signals; the bench resolves the wire
// Operation
// R1: Living low pin zeroes output, keeps on
// R2: Living pin high restores output automatically
// R3: Open pin reads high, no effect in normal polarity
// R4: Invert makes high the inhibiting level
// R5: Living inhibit shows indication, output prohibited
// R6: Latch pulse while on clears on state
// R7: No automatic re-enable after latched inhibit
// R8: Latch sets protection; switch-on after clear
// R9: Latch mode open pin leaves output alone
// R10: Output true drives low, inverted high
// R11: Output pin carries configurable PWM wave
// R12: Two-stage synchroniser before pin detection
`timescale 1ns/10ps
`default_nettype none
module external_output_inhibit_pin
(
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire inhibit_pin_pkg::pin_cfg_s i_cfg,
  input  wire logic                      i_pin,
  input  wire logic                      i_switch_on,
  input  wire logic                      i_switch_off,
  input  wire logic                      i_protection_clear,
  output logic                           o_pin,
  output logic                           o_pin_oe,
  output logic                           o_output_on,
  output logic                           o_output_enable,
  output logic                           o_inhibit_indication,
  output logic                           o_latched_inhibit_protection_indication
);
  import inhibit_pin_pkg::*;

  pin_state_s state;
  pin_state_s next_state;
  logic       pin_active;
  logic       pin_input_mode;
  logic       latch_edge;
  logic       living_inhibit;

  always_comb begin
    next_state = state;
    // Synchroniser and edge detect
    next_state.sync = {state.sync[0], i_pin};                           // [R12]
    next_state.pin_prev = state.sync[1];
    pin_input_mode = (i_cfg.mode == PIN_IN_LIVING) || (i_cfg.mode == PIN_IN_LATCH);
    pin_active = state.sync[1] ^ ~i_cfg.invert;                         // [R3] [R4]
    latch_edge = (i_cfg.mode == PIN_IN_LATCH) && pin_active
                 && ((state.pin_prev ^ ~i_cfg.invert) == 1'b0);         // [R9]
    living_inhibit = (i_cfg.mode == PIN_IN_LIVING) && pin_active;       // [R1] [R5]

    // Operator commands and latched inhibit
    if (i_switch_off) begin
      next_state.output_on = 1'b0;
    end else if (i_switch_on && !state.protection && !latch_edge) begin
      next_state.output_on = 1'b1;                                      // [R7] [R8]
    end
    if (latch_edge && state.output_on) begin
      next_state.output_on = 1'b0;                                      // [R6]
      next_state.protection = 1'b1;                                     // [R8]
    end else if (i_protection_clear) begin
      next_state.protection = 1'b0;
    end

    // PWM period counter
    if (state.pwm_cnt + 16'h0001 >= i_cfg.pwm_period) begin
      next_state.pwm_cnt = PWM_CNT_RESET;                               // [R11]
    end else begin
      next_state.pwm_cnt = state.pwm_cnt + 16'h0001;
    end

    // Pin drive
    unique case (i_cfg.mode)
      PIN_OUT_LEVEL: next_state.drive_level = i_cfg.out_level_true ^ ~i_cfg.invert; // [R10]
      PIN_OUT_PWM:   next_state.drive_level = (state.pwm_cnt < i_cfg.pwm_high) ^ i_cfg.invert; // [R11]
      PIN_IN_LIVING,
      PIN_IN_LATCH:  next_state.drive_level = 1'b1;
    endcase
    next_state.drive_en = !pin_input_mode;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state.output_on   <= OUT_ON_RESET;
      state.protection  <= PROT_ON_RESET;
      state.sync        <= SYNC_RESET;
      state.pin_prev    <= 1'b1;
      state.pwm_cnt     <= PWM_CNT_RESET;
      state.drive_level <= 1'b1;
      state.drive_en    <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign o_pin = state.drive_level;
  assign o_pin_oe = state.drive_en;
  assign o_output_on = state.output_on;                                 // [R1]
  assign o_output_enable = state.output_on && !living_inhibit;          // [R1] [R2]
  assign o_inhibit_indication = living_inhibit;                         // [R5]
  assign o_latched_inhibit_protection_indication = state.protection;    // [R8]

  // Living inhibit
  AST_LIVING_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R1]
    (i_cfg.mode == PIN_IN_LIVING && $past(i_pin, 2) == i_cfg.invert) |-> !o_output_enable)
    else $error("output enabled while living inhibit active");

  AST_LIVING_KEEP_ON: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R1]
    (living_inhibit && o_output_on && !i_switch_off && !latch_edge) |=> o_output_on)
    else $error("on state lost during living inhibit");

  AST_LIVING_RESTORE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R2]
    (i_cfg.mode == PIN_IN_LIVING && $past(i_pin, 2) != i_cfg.invert && o_output_on) |-> o_output_enable)
    else $error("output not restored after release");

  AST_OPEN_PIN: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R3]
    (i_cfg.mode == PIN_IN_LIVING && !i_cfg.invert && state.sync[1]) |-> !o_inhibit_indication)
    else $error("high pin inhibited in normal polarity");

  AST_INVERT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R4]
    (i_cfg.mode == PIN_IN_LIVING && i_cfg.invert && state.sync[1]) |-> o_inhibit_indication)
    else $error("inverted high pin did not inhibit");

  AST_INHIBIT_IND: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R5]
    (i_cfg.mode == PIN_IN_LIVING && $past(i_pin, 2) == i_cfg.invert) |-> o_inhibit_indication)
    else $error("inhibit indication missing");

  AST_LIVING_IND_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R2]
    (i_cfg.mode == PIN_IN_LIVING && $past(i_pin, 2) != i_cfg.invert) |-> !o_inhibit_indication)
    else $error("inhibit indication kept after release");

  AST_NO_IND_LATCH: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R5]
    (i_cfg.mode != PIN_IN_LIVING) |-> !o_inhibit_indication)
    else $error("inhibit indication outside living mode");

  AST_LIVING_NO_PROT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R2]
    (i_cfg.mode == PIN_IN_LIVING && !o_latched_inhibit_protection_indication)
    |=> !o_latched_inhibit_protection_indication)
    else $error("living inhibit set protection");

  AST_PIN_RELEASED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R3]
    (i_cfg.mode == PIN_IN_LIVING || i_cfg.mode == PIN_IN_LATCH) |=> !o_pin_oe)
    else $error("pin driven in input mode");

  // Latched inhibit and operator commands
  AST_LATCH_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R6]
    (latch_edge && o_output_on) |=> (!o_output_on && o_latched_inhibit_protection_indication))
    else $error("latch pulse did not switch off");

  AST_LATCH_OPEN: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R9]
    (i_cfg.mode == PIN_IN_LATCH && $past(i_pin, 2) != i_cfg.invert && !i_switch_on && !i_switch_off)
    |=> (o_output_on == $past(o_output_on)))
    else $error("idle pin changed output state");

  AST_NO_SELF_ON: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R7]
    (!o_output_on && !i_switch_on) |=> !o_output_on)
    else $error("output came on without command");

  AST_PROT_BLOCKS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R8]
    (o_latched_inhibit_protection_indication && !o_output_on) |=> !o_output_on)
    else $error("switch-on accepted during protection");

  AST_PROT_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R8]
    (o_latched_inhibit_protection_indication && !i_protection_clear) |=> o_latched_inhibit_protection_indication)
    else $error("protection dropped without clear");

  AST_PROT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R8]
    (o_latched_inhibit_protection_indication && i_protection_clear && !o_output_on)
    |=> !o_latched_inhibit_protection_indication)
    else $error("protection not cleared");

  AST_PROT_SET_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R8]
    (!o_latched_inhibit_protection_indication && !o_output_on) |=> !o_latched_inhibit_protection_indication)
    else $error("protection set while output off");

  AST_SWITCH_ON: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R7]
    (i_switch_on && !i_switch_off && !o_latched_inhibit_protection_indication && i_cfg.mode != PIN_IN_LATCH)
    |=> o_output_on)
    else $error("switch-on not accepted");

  AST_SWITCH_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R7]
    i_switch_off |=> !o_output_on)
    else $error("switch-off not accepted");

  // Pin as output
  AST_LEVEL_OUT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R10]
    ($stable(i_cfg) && i_cfg.mode == PIN_OUT_LEVEL)
    |=> (o_pin_oe && o_pin == ($past(i_cfg.out_level_true) ^ ~$past(i_cfg.invert))))
    else $error("level output wrong");

  AST_PWM_RANGE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R11]
    (state.pwm_cnt < i_cfg.pwm_period) |=> (state.pwm_cnt < $past(i_cfg.pwm_period)))
    else $error("pwm counter left its period");

  AST_PWM_STEP: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R11]
    (state.pwm_cnt + 16'h0001 < i_cfg.pwm_period) |=> (state.pwm_cnt == $past(state.pwm_cnt) + 16'h0001))
    else $error("pwm counter did not step");

  AST_PWM_ACTIVE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R11]
    (i_cfg.mode == PIN_OUT_PWM && state.pwm_cnt < i_cfg.pwm_high) |=> (o_pin_oe && o_pin == ~$past(i_cfg.invert)))
    else $error("pwm active phase wrong");

  AST_PWM_INACTIVE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R11]
    (i_cfg.mode == PIN_OUT_PWM && state.pwm_cnt >= i_cfg.pwm_high) |=> (o_pin_oe && o_pin == $past(i_cfg.invert)))
    else $error("pwm inactive phase wrong");

  // Synchroniser
  AST_SYNC: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R12]
    1'b1 |=> ##1 (state.sync[1] == $past(i_pin, 2)))
    else $error("synchroniser depth wrong");

  AST_SYNC_PREV: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [R12]
    1'b1 |=> (state.pin_prev == $past(state.sync[1])))
    else $error("edge detect history wrong");

  // Main scenarios
  COV_LIVING: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_output_on && o_inhibit_indication);
  COV_LATCH: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    latch_edge && o_output_on);
  COV_PWM: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_cfg.mode == PIN_OUT_PWM && $rose(o_pin));
  COV_LATCH_REFUSED: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_latched_inhibit_protection_indication && i_switch_on);
  COV_INVERT_INHIBIT: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_cfg.invert && o_inhibit_indication);
endmodule
`default_nettype wire

// ===== verification/pin_source.sv
// Purpose: Far-side model that drives or releases the inhibit pin
// Assumes: Pull-up on the wire
// Notes:   Block drive wins while its enable is high
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input  wire logic i_drive_en,
  input  wire logic i_level,
  input  wire logic i_dut_pin,
  input  wire logic i_dut_oe,
  output logic      o_wire
);
  // Released pin floats to the pull-up level
  assign o_wire = i_dut_oe ? i_dut_pin : (i_drive_en ? i_level : 1'b1);
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the inhibit pin block
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Each scenario task judges its own results
`timescale 1ns/10ps
`default_nettype none
module tb;
  import inhibit_pin_pkg::*;
  logic       i_clk = 0, i_reset_n = 0, ext_en = 0, ext_lvl = 1;
  logic [2:0] c = 0;
  pin_cfg_s   cfg = '0;
  wire        pin, o_pin, oe, on, en, ind, prot;
  int         miscompares = 0, n_compared = 0, cycles = 0, ones;
  external_output_inhibit_pin dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg(cfg), .i_pin(pin),
    .i_switch_on(c[2]), .i_switch_off(c[1]), .i_protection_clear(c[0]), .o_pin(o_pin), .o_pin_oe(oe),
    .o_output_on(on), .o_output_enable(en), .o_inhibit_indication(ind),
    .o_latched_inhibit_protection_indication(prot));
  pin_source src_u (.i_drive_en(ext_en), .i_level(ext_lvl), .i_dut_pin(o_pin), .i_dut_oe(oe), .o_wire(pin));
  initial forever #50 i_clk = ~i_clk;
  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic cmd(input logic [2:0] v);
    @(posedge i_clk) c <= v;
    @(posedge i_clk) c <= 3'h0;
    cyc(2);
  endtask
  task automatic setcfg(input pin_mode_e m, input logic inv, input logic t);
    @(posedge i_clk) cfg <= '{m, inv, t, 16'h0004, 16'h0001};
    cyc(3);
  endtask
  task automatic drive(input logic e, input logic l);
    @(posedge i_clk) begin
      ext_en <= e;
      ext_lvl <= l;
    end
    cyc(4);
  endtask
  task automatic test_living();
    setcfg(PIN_IN_LIVING, 1'b0, 1'b0);
    cmd(3'h4);
    chk({on, en, ind}, 3'h6);
    drive(1'b1, 1'b0);
    chk({on, en, ind}, 3'h5);
    drive(1'b0, 1'b1);
    chk({on, en, ind}, 3'h6);
    setcfg(PIN_IN_LIVING, 1'b1, 1'b0);
    chk({on, en, ind}, 3'h5);
    drive(1'b1, 1'b0);
    chk({on, en, ind}, 3'h6);
    drive(1'b0, 1'b1);
    $display("living test done");
  endtask
  task automatic test_latch();
    setcfg(PIN_IN_LATCH, 1'b0, 1'b0);
    cmd(3'h4);
    chk({on, prot}, 2'h2);
    drive(1'b1, 1'b0);
    chk({on, prot}, 2'h1);
    drive(1'b0, 1'b1);
    cmd(3'h4);
    chk({on, prot}, 2'h1);
    cmd(3'h1);
    chk({on, prot}, 2'h0);
    cmd(3'h4);
    chk({on, prot}, 2'h2);
    cmd(3'h2);
    chk({on, prot}, 2'h0);
    drive(1'b1, 1'b0);
    chk({on, prot}, 2'h0);
    drive(1'b0, 1'b1);
    $display("latch test done");
  endtask
  task automatic test_output();
    for (int k = 0; k < 4; k++) begin
      setcfg(PIN_OUT_LEVEL, k[1], k[0]);
      chk({oe, pin}, {1'b1, ~(k[1] ^ k[0])});
    end
    for (int inv = 0; inv < 2; inv++) begin
      setcfg(PIN_OUT_PWM, inv[0], 1'b0);
      ones = 0;
      repeat (8) begin
        cyc(1);
        ones += int'(pin === 1'b1);
      end
      chk(16'(ones), inv[0] ? 16'h0006 : 16'h0002);
    end
    $display("output test done");
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    test_living();
    test_latch();
    test_output();
    end_sim();
  end
endmodule
`default_nettype wire
